// ### design/psu_seq_pkg.sv
// shared constants of the output enable sequencer
package psu_seq_pkg;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1000;
    localparam int CYC_PER_MS = CLK_HZ / 1000 * TICK_US / 1000;
    localparam int DEBOUNCE_MS = 20;
    // one spare tick because a change may land just before a tick
    localparam int DEBOUNCE_TICKS = DEBOUNCE_MS + 1;
    localparam int PG_DROP_MIN_MS = 2;
    localparam int PG_DROP_MAX_MS = 4;
    localparam int PG_DROP_TICKS = PG_DROP_MIN_MS + 1;
    localparam int INHIBIT_MS = 4200;
    localparam int INHIBIT_TICKS = INHIBIT_MS + 1;
    localparam int AC_LOSS_MS = 20;
    localparam int AC_LOSS_TICKS = AC_LOSS_MS + 1;
    localparam int TMR_W = 13;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [3:0] CTRL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h4;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_INV_BIT = 1;
    localparam logic CTRL_INV_RST = 1'b0;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_REQ_BIT = 2;
    localparam int STAT_PIN_BIT = 3;
    localparam int STAT_SRC_BIT = 4;
    localparam int STAT_AC_BIT = 5;
    localparam int STAT_PG_BIT = 6;
    localparam int STAT_OUT_BIT = 7;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DROP,
        ST_INHIBIT
    } seq_state_t;
endpackage

// ### design/ms_tick_gen.sv
// divider producing a one-cycle enable each millisecond
`timescale 1ns/1ps
module ms_tick_gen #(
    parameter int CYCLES = psu_seq_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // tick
    output logic tick
);
    initial begin
        if (CYCLES < 2 || CYCLES > 65536) begin
            $error("ms_tick_gen: CYCLES out of range");
        end
    end

    logic [15:0] cnt_q;

    always_ff @(posedge clk_sys) begin
        if (reset || cnt_q == 16'(CYCLES - 1)) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tick <= 1'b0;
        end else begin
            tick <= (cnt_q == 16'(CYCLES - 1));
        end
    end
endmodule

// ### design/level_debounce.sv
// accepts a level only after it stays unchanged for a number of ticks
`timescale 1ns/1ps
module level_debounce #(
    parameter int TICKS = psu_seq_pkg::DEBOUNCE_TICKS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // sampling
    input wire logic tick,
    input wire logic rawLevel,
    // result
    output logic stableLevel,
    output logic changed
);
    initial begin
        if (TICKS < 1 || TICKS > 255) begin
            $error("level_debounce: TICKS out of range");
        end
    end

    logic [7:0] cnt_q;

    // any return to the stable level restarts the count, so a glitch never passes
    always_ff @(posedge clk_sys) begin
        if (reset || rawLevel == stableLevel) begin
            cnt_q <= 8'h00;
        end else if (tick) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stableLevel <= 1'b0;
            changed <= 1'b0;
        end else begin
            changed <= 1'b0;
            if (rawLevel != stableLevel && tick && cnt_q == 8'(TICKS - 1)) begin
                stableLevel <= rawLevel;
                changed <= 1'b1;
            end
        end
    end
endmodule

// ### design/psu_output_enable_sequencer.sv
// output enable sequencer: request filter, power-good, restart inhibit, leds
//
// Operation
// R1: power-good is high only while outputs are on, all rails are in regulation and hold-up energy is stored.
// R2: once AC input has been gone for more than 20 ms power-good goes low.
// R3: the power-good LED follows power-good exactly.
// R4: the standby LED is lit while the accepted output request is inactive; the code drives it from the debounced pin level (pinActive) only.
// R5: a low request pin enables main and fan outputs; the standby supply is never touched here.
// R6: a new request pin level is accepted only after it stays unchanged for 20 ms; the host holds changes that long.
// R7: on an accepted inactive request power-good drops, 2 to 4 ms pass, then outputs go off and inhibit starts.
// R8: after every turn-off the outputs stay off for at least 4.2 s whatever the request does.
// R9: if the request is still active when inhibit ends the outputs come back on by themselves.
// R10: between the pin and software on/off commands the most recent change wins.
// R11: with the polarity option set the request pin is active high instead of active low.
// R12: the AC LED is lit whenever AC input is present.
// R13: power-good high promises at least 2 ms more of regulated output.
// R14: all intervals run from one millisecond tick; reset clears counters and disables the outputs.
`timescale 1ns/1ps
module psu_output_enable_sequencer #(
    parameter int CYC_PER_MS = psu_seq_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // host link and power stage status
    input wire logic outputRequestIn,
    input wire logic acPresent,
    input wire logic railsInRegulation,
    input wire logic holdUpReady,
    // power stage control and indicators
    output logic mainOutputEn,
    output logic auxFanOutputEn,
    output logic powerGood,
    output logic powerGoodLed,
    output logic standbyLed,
    output logic acLed
);
    initial begin
        if (CYC_PER_MS < 2) begin
            $error("psu_output_enable_sequencer: CYC_PER_MS too small");
        end
    end

    // ----------------------------------------------------------------
    // millisecond tick and request filter
    // ----------------------------------------------------------------
    logic msTick;
    logic invert_q;
    logic pinActive;
    logic pinChanged;
    logic pinRaw;

    ms_tick_gen #(
        .CYCLES(CYC_PER_MS)
    ) u_tick (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(msTick) // R14
    );

    // pin is low-true unless the polarity option is set
    assign pinRaw = invert_q ? outputRequestIn : ~outputRequestIn; // R11 R5

    level_debounce #(
        .TICKS(psu_seq_pkg::DEBOUNCE_TICKS)
    ) u_deb (
        .clk_sys(clk_sys),
        .reset(reset),
        .tick(msTick),
        .rawLevel(pinRaw),
        .stableLevel(pinActive), // R6
        .changed(pinChanged)
    );

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic busReq;
    logic wrCtrl;
    logic swCmd_q;
    logic swLast_q;
    logic request_q;

    // only the word index is decoded, so byte offsets alias onto their word
    function automatic logic hits(input logic [3:0] adr, input logic [3:0] regAdr);
        hits = (adr[3:2] == regAdr[3:2]);
    endfunction

    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrCtrl = busReq && wb_we_i && wb_sel_i[0] && hits(wb_adr_i, psu_seq_pkg::CTRL_ADDR);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busReq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            invert_q <= psu_seq_pkg::CTRL_INV_RST;
            swCmd_q <= 1'b0;
        end else if (wrCtrl) begin
            invert_q <= wb_dat_i[psu_seq_pkg::CTRL_INV_BIT];
            swCmd_q <= wb_dat_i[psu_seq_pkg::CTRL_ON_BIT];
        end
    end

    // ----------------------------------------------------------------
    // request arbitration
    // ----------------------------------------------------------------
    // a software write counts as a command even if it repeats the value;
    // if both arrive in one cycle the software command is taken as later
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            request_q <= 1'b0;
            swLast_q <= 1'b0;
        end else if (wrCtrl) begin
            request_q <= wb_dat_i[psu_seq_pkg::CTRL_ON_BIT]; // R10
            swLast_q <= 1'b1;
        end else if (pinChanged) begin
            request_q <= pinActive; // R10
            swLast_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // AC loss timer
    // ----------------------------------------------------------------
    logic [7:0] acLossCnt_q;
    logic acLost;

    always_ff @(posedge clk_sys) begin
        if (reset || acPresent) begin
            acLossCnt_q <= 8'h00;
        end else if (msTick && !acLost) begin
            acLossCnt_q <= acLossCnt_q + 8'h01;
        end
    end

    assign acLost = (acLossCnt_q >= 8'(psu_seq_pkg::AC_LOSS_TICKS)); // R2

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    psu_seq_pkg::seq_state_t state_q;
    logic [psu_seq_pkg::TMR_W-1:0] tmr_q;
    logic tmrDone;
    logic outputsOn;
    logic pgNext;

    assign tmrDone = (tmr_q == '0);
    assign outputsOn = (state_q == psu_seq_pkg::ST_RUN) || (state_q == psu_seq_pkg::ST_DROP);

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_q <= psu_seq_pkg::ST_IDLE; // R14
            tmr_q <= '0;
        end else begin
            if (msTick && !tmrDone) begin
                tmr_q <= tmr_q - 1'b1; // R14
            end
            unique case (state_q)
                psu_seq_pkg::ST_IDLE: begin
                    if (request_q) begin
                        state_q <= psu_seq_pkg::ST_RUN;
                    end
                end
                psu_seq_pkg::ST_RUN: begin
                    if (!request_q) begin
                        state_q <= psu_seq_pkg::ST_DROP; // R7
                        tmr_q <= psu_seq_pkg::TMR_W'(psu_seq_pkg::PG_DROP_TICKS);
                    end
                end
                psu_seq_pkg::ST_DROP: begin
                    // power-good already low; outputs stay up 2 to 3 ms
                    if (tmrDone) begin
                        state_q <= psu_seq_pkg::ST_INHIBIT; // R7 R13
                        tmr_q <= psu_seq_pkg::TMR_W'(psu_seq_pkg::INHIBIT_TICKS); // R8
                    end
                end
                psu_seq_pkg::ST_INHIBIT: begin
                    // renewed requests wait here; a held request restarts alone
                    if (tmrDone) begin
                        state_q <= request_q ? psu_seq_pkg::ST_RUN : psu_seq_pkg::ST_IDLE; // R8 R9
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // power-good falls with the request, ahead of the outputs, so the
    // host always sees it low for the drop interval before rails go
    assign pgNext = (state_q == psu_seq_pkg::ST_RUN) && request_q && railsInRegulation
        && holdUpReady && !acLost; // R1 R2 R13

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            powerGood <= 1'b0;
            powerGoodLed <= 1'b0;
        end else begin
            powerGood <= pgNext; // R1
            powerGoodLed <= pgNext; // R3
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            mainOutputEn <= 1'b0; // R14
            auxFanOutputEn <= 1'b0;
            standbyLed <= 1'b0;
            acLed <= 1'b0;
        end else begin
            mainOutputEn <= outputsOn; // R5
            auxFanOutputEn <= outputsOn; // R5
            standbyLed <= !pinActive; // R4
            acLed <= acPresent; // R12
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busReq && !wb_we_i) begin
            if (hits(wb_adr_i, psu_seq_pkg::CTRL_ADDR)) begin
                wb_dat_o <= {30'h0000_0000, invert_q, swCmd_q};
            end else if (hits(wb_adr_i, psu_seq_pkg::STAT_ADDR)) begin
                wb_dat_o <= {24'h00_0000, outputsOn, powerGood, acPresent, swLast_q,
                    pinActive, request_q, state_q};
            end else begin
                wb_dat_o <= psu_seq_pkg::UNMAPPED_DATA;
            end
        end
    end
endmodule

// ### dv/psu_seq_monitor.sv
// assertion checker of the output enable sequencer
`timescale 1ns/1ps
module psu_seq_monitor #(
    parameter int CYC_PER_MS = psu_seq_pkg::CYC_PER_MS
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // status in
    input wire logic acPresent,
    input wire logic railsInRegulation,
    input wire logic holdUpReady,
    // outputs
    input wire logic mainOutputEn,
    input wire logic auxFanOutputEn,
    input wire logic powerGood,
    input wire logic powerGoodLed,
    input wire logic acLed
);
    localparam int OFF_MIN = 4200 * CYC_PER_MS;
    localparam int PG_LEAD = 2 * CYC_PER_MS;
    // two spare cycles for the loss counter register and the registered power-good behind it
    localparam int AC_MAX = 22 * CYC_PER_MS + 2;
    int offCnt_q;
    int pgLowCnt_q;
    int acLowCnt_q;
    logic armed_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        offCnt_q <= (reset || mainOutputEn) ? 0 : offCnt_q + 1;
        pgLowCnt_q <= (reset || powerGood) ? 0 : pgLowCnt_q + 1;
        acLowCnt_q <= (reset || acPresent) ? 0 : acLowCnt_q + 1;
        armed_q <= reset ? 1'b0 : (armed_q || $fell(mainOutputEn));
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK: assert property (s_req |=> s_pulse) else $error("ack not one pulse");
    AST_PG_LED: assert property (powerGoodLed == powerGood) else $error("led differs");
    AST_FAN: assert property (auxFanOutputEn == mainOutputEn) else $error("fan differs");
    AST_AC_LED: assert property (acPresent |=> acLed) else $error("ac led dark");
    AST_PG_ON: assert property (powerGood |-> mainOutputEn) else $error("pg while off");
    AST_PG_RAIL: assert property (!(railsInRegulation && holdUpReady) |-> ##[1:2] !powerGood) else $error("pg bad");
    AST_AC_LOSS: assert property (acLowCnt_q > AC_MAX |-> !powerGood) else $error("pg after ac loss");
    AST_OFF_HOLD: assert property ($rose(mainOutputEn) && armed_q |-> offCnt_q >= OFF_MIN) else $error("short off");
    AST_PG_LEAD: assert property ($fell(mainOutputEn) |-> pgLowCnt_q >= PG_LEAD) else $error("pg late");
    AST_RST: assert property (disable iff (1'b0) reset |=> !mainOutputEn && !powerGood) else $error("on in reset");
endmodule

bind psu_output_enable_sequencer psu_seq_monitor #(.CYC_PER_MS(CYC_PER_MS)) mon (.clk_sys(clk_sys), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .acPresent(acPresent),
    .railsInRegulation(railsInRegulation), .holdUpReady(holdUpReady), .mainOutputEn(mainOutputEn),
    .auxFanOutputEn(auxFanOutputEn), .powerGood(powerGood), .powerGoodLed(powerGoodLed), .acLed(acLed));

// ### dv/host_request_model.sv
// host side model driving the output request pin
`timescale 1ns/1ps
module host_request_model #(
    parameter int HOLD = 210
) (
    // clock
    input wire logic clk_sys,
    // bench control
    input wire logic wantOn,
    input wire logic invert,
    input wire logic allowShort,
    // pin
    output logic outputRequestIn
);
    logic want_q = 1'b0;
    int hold_q = HOLD;
    // released pin rests at its pull level, which is the inactive one
    assign outputRequestIn = want_q ~^ invert;
    always @(posedge clk_sys) begin
        if (wantOn != want_q && (hold_q >= HOLD || allowShort)) begin
            want_q <= wantOn;
            hold_q <= 0;
        end else if (hold_q < HOLD) begin
            hold_q <= hold_q + 1;
        end
    end
endmodule

// ### dv/testbench.sv
// self-checking bench of the output enable sequencer
`timescale 1ns/1ps
module testbench;
    localparam int CPM = 10;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [3:0] wbAdr = 4'h0;
    logic [3:0] wbSel = 4'hf;
    logic [31:0] wbDatI = 32'h0000_0000;
    logic [31:0] wbDatO, rd;
    logic wbAck, pin, mainEn, fanEn, pg, pgLed, sbLed, acLed;
    logic acOk = 1'b1, rails = 1'b1, holdUp = 1'b1, wantOn = 1'b0, invert = 1'b0, allowShort = 1'b0;
    int failures = 0;
    int tests_run = 0;
    int n;
    psu_output_enable_sequencer #(.CYC_PER_MS(CPM)) uut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wbCyc),
        .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .outputRequestIn(pin), .acPresent(acOk), .railsInRegulation(rails), .holdUpReady(holdUp),
        .mainOutputEn(mainEn), .auxFanOutputEn(fanEn), .powerGood(pg), .powerGoodLed(pgLed), .standbyLed(sbLed),
        .acLed(acLed));
    host_request_model #(.HOLD(21 * CPM)) host (.clk_sys(clk_sys), .wantOn(wantOn), .invert(invert),
        .allowShort(allowShort), .outputRequestIn(pin));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        check({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatI <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDatO;
        if (n >= 20) failures++;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic waitFor(ref logic s, input logic v, input int lim);
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic ms(input int k);
        repeat (k * CPM) @(posedge clk_sys);
    endtask
    function automatic logic expPg(input logic r, input logic h, input logic a);
        return r & h & a;
    endfunction
    function automatic logic inRange(input int c, input int lo, input int hi);
        return c >= lo && c <= hi;
    endfunction
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (100000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        void'($urandom(60641));
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        checkBit(mainEn, 1'b0);
        repeat (2) @(posedge clk_sys);
        checkBit(sbLed, 1'b1);
        checkBit(acLed, 1'b1);
        wb(1'b1, 4'h8, $urandom());
        wb(1'b0, 4'h8, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        wb(1'b1, psu_seq_pkg::CTRL_ADDR, 32'h0000_0000);
        $display("test regs done");
        wantOn <= 1'b1;
        ms(19);
        checkBit(mainEn, 1'b0);
        waitFor(mainEn, 1'b1, 40);
        @(posedge clk_sys);
        checkBit(fanEn, 1'b1);
        checkBit(pg, 1'b1);
        checkBit(sbLed, 1'b0);
        wb(1'b0, psu_seq_pkg::STAT_ADDR, 32'h0000_0000);
        check(rd & 32'h0000_00ff, 32'h0000_00ed);
        allowShort <= 1'b1;
        wantOn <= 1'b0;
        ms(10);
        wantOn <= 1'b1;
        @(posedge clk_sys);
        allowShort <= 1'b0;
        ms(25);
        checkBit(mainEn, 1'b1);
        repeat (8) begin
            rails <= 1'($urandom());
            holdUp <= 1'($urandom());
            repeat (3) @(posedge clk_sys);
            checkBit(pg, expPg(rails, holdUp, acOk));
            checkBit(pgLed, expPg(rails, holdUp, acOk));
        end
        rails <= 1'b1;
        holdUp <= 1'b1;
        acOk <= 1'b0;
        ms(15);
        checkBit(pg, 1'b1);
        checkBit(acLed, 1'b0);
        acOk <= 1'b1;
        ms(1);
        acOk <= 1'b0;
        ms(25);
        checkBit(pg, 1'b0);
        acOk <= 1'b1;
        ms(1);
        checkBit(pg, 1'b1);
        $display("test pin and pg done");
        wb(1'b1, psu_seq_pkg::CTRL_ADDR, 32'h0000_0000);
        checkBit(pg, 1'b0);
        waitFor(mainEn, 1'b0, 60);
        checkBit(inRange(n, 15, 38), 1'b1);
        ms(1000);
        wb(1'b1, psu_seq_pkg::CTRL_ADDR, 32'h0000_0001);
        ms(3195);
        checkBit(mainEn, 1'b0);
        waitFor(mainEn, 1'b1, 100);
        checkBit(mainEn, 1'b1);
        $display("test software off done");
        wantOn <= 1'b0;
        waitFor(pg, 1'b0, 300);
        waitFor(mainEn, 1'b0, 60);
        checkBit(inRange(n, 19, 40), 1'b1);
        checkBit(sbLed, 1'b1);
        wb(1'b0, psu_seq_pkg::STAT_ADDR, 32'h0000_0000);
        check(rd & 32'h0000_0003, 32'h0000_0003);
        wb(1'b1, psu_seq_pkg::CTRL_ADDR, 32'h0000_0002);
        invert <= 1'b1;
        ms(25);
        wantOn <= 1'b1;
        waitFor(mainEn, 1'b1, 43000);
        checkBit(mainEn, 1'b1);
        @(posedge clk_sys);
        checkBit(sbLed, 1'b0);
        $display("test pin off and inversion done");
        end_of_test();
    end
endmodule
